// [src/lps_consts.svh]
// offsets, field positions, reset values and codes of the low power sequencer
// assumes byte addresses on a 32-bit AHB-Lite bus, one word per register
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH
`define LPS_CTRL_OFS 12'h000
`define LPS_STAT_OFS 12'h004
`define LPS_MASK_OFS 12'h008
`define LPS_FLAG_OFS 12'h00C
`define LPS_FSET_OFS 12'h010
`define LPS_ISLOT_BASE 12'h080
`define LPS_GSLOT_BASE 12'h100
`define LPS_ISLOTS 32
`define LPS_GSLOTS 16
`define LPS_CTRL_RUN 0
`define LPS_CTRL_STOP 1
`define LPS_CTRL_TSEL_LSB 8
`define LPS_TSEL_RST 5'h00
`define LPS_EV_END 0
`define LPS_EV_FSTOP 1
`define LPS_EV_FAULT 2
`define LPS_MASK_RST 3'h7
`define LPS_FLAG_RST 3'h0
`define LPS_OP_BSET 4'h4
`define LPS_OP_BCLR 4'h5
`define LPS_TERM_WORD 16'hF000
`define LPS_IRQ_TARGET 4'hF
`define LPS_TRIGGERED_WAKE_MODE_GS_LIMIT 4'hC
`endif

// [src/lps_pkg.sv]
// types shared by the low power sequencer files
// assumes lps_consts.svh holds the offsets and codes; some field positions and values stay literal in the code
package lps_pkg;
   typedef enum logic [1:0] {LPS_STOPPED, LPS_WAIT_TRIG, LPS_OPERATING} lps_state_e;
   typedef enum logic [1:0] {LPS_MODE_RUN, LPS_MODE_HALT, LPS_MODE_STOP} lps_chip_mode_e;
   typedef logic [15:0] lps_word_t;
endpackage

// [src/lps_sequencer_ctrl.sv]
// run control and low power behaviour of the micro-coded sequencer, AHB-Lite slave
// assumes one clock, synchronous pulse triggers and chip mode inputs from the power unit
//
// The register offsets and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "lps_consts.svh"
module lps_sequencer_ctrl
   import lps_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [31:0] trigger_in,
   input wire logic [1:0] chip_mode,
   input wire logic subsys_clk_selected,
   input wire logic rtc_low_power_select,
   input wire logic fast_osc_selected,
   output logic triggered_wake_mode,
   output logic seq_end_interrupt
);
   lps_slot_if slots ();

   lps_slot_mem u_mem (
      .clk(clk),
      .reset_n(reset_n),
      .slots(slots)
   );

   lps_state_e state;
   logic sequencer_run_bit;
   logic [4:0] trigger_select_field;
   logic [4:0] program_counter_field;
   logic [2:0] irq_mask_reg_high;
   logic [2:0] irq_flag_reg_high;
   logic wr_pend;
   logic rd_pend;
   logic [11:0] dp_addr;
   logic [2:0] ev_set;

   function automatic logic slot_hit(input logic [11:0] a, input logic [11:0] base,
      input int n);
      logic [11:0] top;
      top = base + 12'(n * 4);
      slot_hit = (a >= base) && (a < top);
   endfunction

   function automatic logic is_term(input lps_word_t w);
      is_term = (w == `LPS_TERM_WORD);
   endfunction

   // bus side: writes take effect in the data phase, reads add one wait state
   logic take;
   assign take = hsel && hready && htrans[1];
   assign hresp = 1'b0;
   assign hreadyout = !rd_pend;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 12'h000;
      end
      else
      begin
         wr_pend <= take && hwrite;
         rd_pend <= take && !hwrite;
         if (take)
            dp_addr <= haddr[11:0];
      end
   end

   logic wr_ctrl;
   logic wr_mask;
   logic wr_flag;
   logic wr_fset;
   logic wr_islot;
   logic wr_gslot;
   logic force_stop_bit;
   assign wr_ctrl = wr_pend && dp_addr == `LPS_CTRL_OFS;
   assign wr_mask = wr_pend && dp_addr == `LPS_MASK_OFS;
   assign wr_flag = wr_pend && dp_addr == `LPS_FLAG_OFS;
   assign wr_fset = wr_pend && dp_addr == `LPS_FSET_OFS;
   assign wr_islot = wr_pend && slot_hit(dp_addr, `LPS_ISLOT_BASE, `LPS_ISLOTS);
   assign wr_gslot = wr_pend && slot_hit(dp_addr, `LPS_GSLOT_BASE, `LPS_GSLOTS);
   assign force_stop_bit = wr_ctrl && hwdata[`LPS_CTRL_STOP];

   assign slots.cpu_we = wr_islot || wr_gslot;
   assign slots.cpu_gen = (dp_addr >= `LPS_GSLOT_BASE);
   assign slots.cpu_idx = dp_addr[6:2];
   assign slots.cpu_wdata = hwdata[15:0];

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         hrdata <= 32'h0000_0000;
      else if (rd_pend)
      begin
         if (dp_addr == `LPS_CTRL_OFS)
            hrdata <= {19'h0, trigger_select_field, 7'h0, sequencer_run_bit};
         else if (dp_addr == `LPS_STAT_OFS)
            hrdata <= {19'h0, triggered_wake_mode, 2'h0, state, 3'h0, program_counter_field};
         else if (dp_addr == `LPS_MASK_OFS)
            hrdata <= {29'h0, irq_mask_reg_high};
         else if (dp_addr == `LPS_FLAG_OFS)
            hrdata <= {29'h0, irq_flag_reg_high};
         else if (slot_hit(dp_addr, `LPS_ISLOT_BASE, `LPS_ISLOTS))
            hrdata <= {16'h0000, slots.cpu_rdata};
         else if (slot_hit(dp_addr, `LPS_GSLOT_BASE, `LPS_GSLOTS))
            hrdata <= {16'h0000, slots.cpu_rdata};
         else
            hrdata <= 32'h0000_0000;
      end
   end

   // operating conditions
   logic op_allowed;
   logic in_stop;
   logic run_ok;
   logic trig_hit;
   logic accept;
   assign op_allowed = !(subsys_clk_selected && rtc_low_power_select);
   assign in_stop = (chip_mode == LPS_MODE_STOP);
   assign run_ok = op_allowed && (!in_stop || triggered_wake_mode);
   assign trig_hit = trigger_in[trigger_select_field];
   assign accept = state == LPS_WAIT_TRIG && trig_hit && op_allowed &&
      (!in_stop || fast_osc_selected);

   // instruction execute
   lps_word_t instr;
   logic exec;
   logic exec_term;
   logic bit_op;
   logic irq_target;
   logic blocked;
   logic mask_clear;
   assign slots.seq_iidx = program_counter_field;
   assign instr = slots.seq_instr;
   assign exec = state == LPS_OPERATING && run_ok;
   assign exec_term = exec && is_term(instr);
   assign bit_op = exec && (instr[15:12] == `LPS_OP_BSET || instr[15:12] == `LPS_OP_BCLR);
   assign irq_target = instr[11:8] == `LPS_IRQ_TARGET;
   assign blocked = bit_op && !irq_target && triggered_wake_mode &&
      instr[11:8] >= `LPS_TRIGGERED_WAKE_MODE_GS_LIMIT;
   assign mask_clear = bit_op && irq_target && instr[15:12] == `LPS_OP_BCLR &&
      instr[7:4] == 4'h0;
   assign slots.seq_gidx = instr[11:8];
   assign slots.seq_gwe = bit_op && !irq_target && !blocked;

   always_comb
   begin
      slots.seq_gwdata = slots.seq_grdata;
      slots.seq_gwdata[instr[7:4]] = (instr[15:12] == `LPS_OP_BSET);
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         state <= LPS_STOPPED;
      else if (force_stop_bit)
         state <= LPS_STOPPED;
      else if (wr_ctrl && !hwdata[`LPS_CTRL_RUN])
         state <= LPS_STOPPED;
      else if (wr_ctrl && state == LPS_STOPPED)
         state <= LPS_WAIT_TRIG;
      else if (accept)
         state <= LPS_OPERATING;
      else if (exec_term)
         state <= LPS_WAIT_TRIG;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sequencer_run_bit <= 1'b0;
         trigger_select_field <= `LPS_TSEL_RST;
      end
      else if (force_stop_bit)
      begin
         sequencer_run_bit <= 1'b0;
         trigger_select_field <= `LPS_TSEL_RST;
      end
      else if (wr_ctrl)
      begin
         sequencer_run_bit <= hwdata[`LPS_CTRL_RUN];
         trigger_select_field <= hwdata[`LPS_CTRL_TSEL_LSB +: 5];
      end
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         program_counter_field <= 5'h00;
      else if (force_stop_bit || accept)
         program_counter_field <= 5'h00;
      else if (exec_term)
         program_counter_field <= 5'h00;
      else if (exec)
         program_counter_field <= program_counter_field + 5'h01;
   end

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         triggered_wake_mode <= 1'b0;
      // a run-zero write stops the sequencer, so wake mode must end with it
      else if (force_stop_bit || exec_term || (wr_ctrl && !hwdata[`LPS_CTRL_RUN]))
         triggered_wake_mode <= 1'b0;
      else if (accept && in_stop)
         triggered_wake_mode <= 1'b1;
   end

   assign ev_set[`LPS_EV_END] = mask_clear;
   assign ev_set[`LPS_EV_FSTOP] = force_stop_bit;
   assign ev_set[`LPS_EV_FAULT] = blocked;

   // run bit guard: end mask and flag cannot be cleared by software while running
   logic [2:0] sw_guard;
   assign sw_guard = sequencer_run_bit ? 3'h1 : 3'h0;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_mask_reg_high <= `LPS_MASK_RST;
      else if (mask_clear)
         irq_mask_reg_high[`LPS_EV_END] <= 1'b0;
      else if (wr_mask)
         irq_mask_reg_high <= hwdata[2:0] | (irq_mask_reg_high & sw_guard);
   end

   // set wins over a same-cycle write-one clear
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         irq_flag_reg_high <= `LPS_FLAG_RST;
      else
         irq_flag_reg_high <= (irq_flag_reg_high & ~(wr_flag ? hwdata[2:0] & ~sw_guard : 3'h0))
            | ev_set | (wr_fset ? hwdata[2:0] : 3'h0);
   end

   // mask of one hides the event, as for the chip's own interrupt controller
   assign seq_end_interrupt = |(irq_flag_reg_high & ~irq_mask_reg_high);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_term_exec;
      exec_term ##1 (state == LPS_WAIT_TRIG);
   endsequence

   sequence s_mask_drop;
      mask_clear ##1 (!irq_mask_reg_high[`LPS_EV_END] && irq_flag_reg_high[`LPS_EV_END]);
   endsequence

   ctrl_reinit_a: assert property (force_stop_bit |=> !sequencer_run_bit &&
      trigger_select_field == `LPS_TSEL_RST)
      else $error("control not reset by forced stop");
   forced_stop_a: assert property (force_stop_bit |=> state == LPS_STOPPED)
      else $error("forced stop did not stop");
   term_wait_a: assert property (exec_term && !force_stop_bit && !wr_ctrl
      |-> s_term_exec)
      else $error("termination did not return to waiting");
   term_pc_a: assert property (exec_term |=> program_counter_field == 5'h00)
      else $error("termination left counter nonzero");
   pc_step_a: assert property (exec && !exec_term && !force_stop_bit
      |=> program_counter_field == $past(program_counter_field) + 5'h01)
      else $error("counter did not step");
   rtc_hold_a: assert property (state == LPS_OPERATING && !op_allowed && !force_stop_bit
      |=> $stable(program_counter_field))
      else $error("sequencer ran with rtc low power");
   trig_start_a: assert property (accept && !wr_ctrl
      |=> state == LPS_OPERATING && program_counter_field == 5'h00)
      else $error("trigger did not start at slot zero");
   wake_enter_a: assert property (accept && in_stop && !force_stop_bit
      |=> triggered_wake_mode)
      else $error("stop mode trigger did not wake");
   wake_exit_a: assert property (exec_term |=> !triggered_wake_mode)
      else $error("wake mode kept after end");
   osc_gate_a: assert property ($rose(triggered_wake_mode) |-> $past(fast_osc_selected))
      else $error("wake mode without fast oscillator");
   slot_guard_a: assert property (triggered_wake_mode && slots.seq_gwe
      |-> slots.seq_gidx < `LPS_TRIGGERED_WAKE_MODE_GS_LIMIT)
      else $error("protected slot written in wake mode");
   end_irq_a: assert property (mask_clear |-> s_mask_drop ##0 seq_end_interrupt)
      else $error("end interrupt not raised");
   halt_run_a: assert property (exec && chip_mode == LPS_MODE_HALT && !exec_term
      && !force_stop_bit && !wr_ctrl |=> state == LPS_OPERATING)
      else $error("halt mode stopped the sequencer");
   // guards below back up the software rules and the stop paths
   wake_stop_a: assert property (state == LPS_STOPPED |-> !triggered_wake_mode)
      else $error("wake mode kept while stopped");
   flag_guard_a: assert property (sequencer_run_bit && irq_flag_reg_high[`LPS_EV_END]
      |=> irq_flag_reg_high[`LPS_EV_END])
      else $error("end flag cleared while running");
   mask_guard_a: assert property (sequencer_run_bit && irq_mask_reg_high[`LPS_EV_END]
      && !mask_clear |=> irq_mask_reg_high[`LPS_EV_END])
      else $error("end mask cleared by software while running");
   fault_flag_a: assert property (blocked |=> irq_flag_reg_high[`LPS_EV_FAULT])
      else $error("protected access not flagged");
   wait_trig_a: assert property (state == LPS_WAIT_TRIG && !trig_hit
      |=> state != LPS_OPERATING)
      else $error("sequencer started without its trigger");
endmodule

// [src/lps_slot_if.sv]
// slot storage port between the sequencer control and its slot memory
// assumes one clock; all reads combinational from the memory flops
`timescale 1ns/1ps
interface lps_slot_if;
   import lps_pkg::*;
   logic cpu_we;
   logic cpu_gen;
   logic [4:0] cpu_idx;
   lps_word_t cpu_wdata;
   lps_word_t cpu_rdata;
   logic [4:0] seq_iidx;
   lps_word_t seq_instr;
   logic seq_gwe;
   logic [3:0] seq_gidx;
   lps_word_t seq_gwdata;
   lps_word_t seq_grdata;
   modport ctl (output cpu_we, cpu_gen, cpu_idx, cpu_wdata, seq_iidx, seq_gwe, seq_gidx,
      seq_gwdata, input cpu_rdata, seq_instr, seq_grdata);
   modport mem (input cpu_we, cpu_gen, cpu_idx, cpu_wdata, seq_iidx, seq_gwe, seq_gidx,
      seq_gwdata, output cpu_rdata, seq_instr, seq_grdata);
endinterface

// [src/lps_slot_mem.sv]
// instruction slots and general slots of the sequencer
// assumes chip reset only; a forced stop never reaches this memory
`timescale 1ns/1ps
`include "lps_consts.svh"
module lps_slot_mem
   import lps_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   lps_slot_if.mem slots
);
   lps_word_t islot [`LPS_ISLOTS];
   lps_word_t gslot [`LPS_GSLOTS];

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i < `LPS_ISLOTS; i++)
            islot[i] <= 16'h0000;
      end
      else if (slots.cpu_we && !slots.cpu_gen)
      begin
         islot[slots.cpu_idx] <= slots.cpu_wdata;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `LPS_GSLOTS; g++)
      begin : gen_gslot
         // the sequencer wins a same-cycle clash; software should not poke live data
         always_ff @(posedge clk or negedge reset_n)
         begin
            if (!reset_n)
               gslot[g] <= 16'h0000;
            else if (slots.seq_gwe && slots.seq_gidx == 4'(g))
               gslot[g] <= slots.seq_gwdata;
            else if (slots.cpu_we && slots.cpu_gen && slots.cpu_idx == 5'(g))
               gslot[g] <= slots.cpu_wdata;
         end
      end
   endgenerate

   assign slots.cpu_rdata = slots.cpu_gen ? gslot[slots.cpu_idx[3:0]] : islot[slots.cpu_idx];
   assign slots.seq_instr = islot[slots.seq_iidx];
   assign slots.seq_grdata = gslot[slots.seq_gidx];
endmodule

// [tb/low_power_sequencer_control_test.sv]
// bench for the sequencer control: ahb-lite master, mode pins, checks
// assumes lps_trig_src drives the trigger lines
`timescale 1ns/1ps
`include "lps_consts.svh"
`define CHK(nm, e, v) begin num_checks++; if ((v) !== (e)) begin mismatches++; \
$display("Error %s expected %h seen %h", nm, e, v); end end
module low_power_sequencer_control_test
   import lps_pkg::*;
;
   logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
   logic subsys = 1'b0, rtclp = 1'b0, fast = 1'b1, hready, hresp, wake, irq;
   logic irq_s, wake_s, resp_s;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat, trig;
   logic [1:0] htrans = 2'h0, chip_mode = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [4:0] tsel = 5'h0, t, pc;
   logic [3:0] g;
   logic [2:0] b;
   int mismatches = 0, num_checks = 0, seed = 34;
   always #50 clk = ~clk;
   lps_sequencer_ctrl dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .trigger_in(trig),
      .chip_mode(chip_mode), .subsys_clk_selected(subsys), .rtc_low_power_select(rtclp),
      .fast_osc_selected(fast), .triggered_wake_mode(wake), .seq_end_interrupt(irq));
   lps_trig_src src (.clk(clk), .reset_n(reset_n), .fire(fire), .sel(tsel),
      .trigger_in(trig));
   function automatic logic [31:0] bit_word(input logic [2:0] n);
      return 32'h1 << n;
   endfunction
   task automatic test_done();
      if (mismatches == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // settled values are taken at the falling edge, never at the launching edge
   task automatic rdy();
      int n;
      logic ok;
      n = 0;
      ok = 1'b0;
      while (!ok && n < 50)
      begin
         @(negedge clk);
         ok = (hready === 1'b1);
         rdat = hrdata;
         irq_s = irq;
         wake_s = wake;
         resp_s = hresp;
         @(posedge clk);
         n++;
      end
      // a hang here counts once and the run goes on to the verdict
      `CHK("bus ready", 1'b1, ok)
      `CHK("bus response", 1'b0, resp_s)
   endtask
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h00000, a};
      rdy();
      htrans <= 2'b00;
      hwdata <= d;
      rdy();
   endtask
   task automatic wait_state(input logic [1:0] s);
      int n;
      n = 0;
      xfer(1'b0, `LPS_STAT_OFS, 32'h0);
      while (rdat[9:8] !== s && n < 20)
      begin
         xfer(1'b0, `LPS_STAT_OFS, 32'h0);
         n++;
      end
   endtask
   task automatic wait_wake(input logic v);
      int n;
      n = 0;
      do
      begin
         @(negedge clk);
         wake_s = wake;
         @(posedge clk);
         n++;
      end
      while (wake_s !== v && n < 20);
   endtask
   task automatic pulse(input logic [4:0] s);
      tsel <= s;
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
   endtask
   task automatic start(input logic [3:0] gs);
      xfer(1'b1, `LPS_CTRL_OFS, 32'h0);
      xfer(1'b1, `LPS_FLAG_OFS, 32'h7);
      xfer(1'b1, `LPS_MASK_OFS, 32'h7);
      xfer(1'b1, `LPS_FSET_OFS, 32'h1);
      xfer(1'b1, `LPS_ISLOT_BASE, {16'h0000, `LPS_OP_BSET, gs, 1'b0, b, 4'h0});
      xfer(1'b1, `LPS_ISLOT_BASE + 12'h004, {16'h0000, `LPS_OP_BCLR, `LPS_IRQ_TARGET, 8'h00});
      xfer(1'b1, `LPS_ISLOT_BASE + 12'h008, {16'h0000, `LPS_TERM_WORD});
      // control set up again before each start
      xfer(1'b1, `LPS_CTRL_OFS, {19'h00000, t, 8'h01});
      xfer(1'b0, `LPS_STAT_OFS, 32'h0);
      `CHK("idle irq", 1'b0, irq_s)
      `CHK("armed state", 2'h1, rdat[9:8])
   endtask
   initial
   begin
      t = 5'($random(seed));
      g = 4'($unsigned($random(seed)) % 12);
      b = 3'($random(seed));
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      xfer(1'b0, `LPS_MASK_OFS, 32'h0);
      `CHK("mask reset", 32'h7, rdat)
      xfer(1'b0, 12'hFFC, 32'h0);
      `CHK("unmapped", 32'h0, rdat)
      chip_mode <= LPS_MODE_HALT;
      start(g);
      pulse(t + 5'h01);
      xfer(1'b0, `LPS_STAT_OFS, 32'h0);
      `CHK("other trigger", 2'h1, rdat[9:8])
      pulse(t);
      wait_state(2'h1);
      `CHK("end state", 2'h1, rdat[9:8])
      `CHK("pc cleared", 5'h00, rdat[4:0])
      `CHK("end irq", 1'b1, irq_s)
      xfer(1'b0, `LPS_GSLOT_BASE + {6'h00, g, 2'b00}, 32'h0);
      `CHK("slot op", bit_word(b), rdat)
      xfer(1'b0, `LPS_MASK_OFS, 32'h0);
      `CHK("mask cleared", 32'h6, rdat)
      xfer(1'b1, `LPS_FLAG_OFS, 32'h1);
      xfer(1'b0, `LPS_FLAG_OFS, 32'h0);
      `CHK("flag kept", 32'h1, rdat)
      chip_mode <= LPS_MODE_STOP;
      fast <= 1'b0;
      start(4'hC + {2'b00, g[1:0]});
      pulse(t);
      wait_state(2'h1);
      `CHK("slow osc wake", 1'b0, wake_s)
      fast <= 1'b1;
      pulse(t);
      wait_wake(1'b1);
      `CHK("wake entered", 1'b1, wake_s)
      wait_state(2'h1);
      `CHK("wake left", 1'b0, wake_s)
      xfer(1'b0, `LPS_GSLOT_BASE + {6'h03, g[1:0], 2'b00}, 32'h0);
      `CHK("protected slot", 32'h0, rdat)
      xfer(1'b0, `LPS_FLAG_OFS, 32'h0);
      `CHK("fault flag", 1'b1, rdat[2])
      start(g);
      pulse(t);
      @(posedge clk);
      subsys <= 1'b1;
      rtclp <= 1'b1;
      xfer(1'b0, `LPS_STAT_OFS, 32'h0);
      pc = rdat[4:0];
      `CHK("held state", 2'h2, rdat[9:8])
      `CHK("held wake", 1'b1, wake_s)
      xfer(1'b0, `LPS_STAT_OFS, 32'h0);
      `CHK("held pc", pc, rdat[4:0])
      xfer(1'b1, `LPS_CTRL_OFS, {19'h00000, t, 8'h02});
      xfer(1'b0, `LPS_STAT_OFS, 32'h0);
      `CHK("stopped", 2'h0, rdat[9:8])
      `CHK("stop wake", 1'b0, wake_s)
      xfer(1'b0, `LPS_FLAG_OFS, 32'h0);
      `CHK("stop flag", 32'h3, rdat)
      xfer(1'b0, `LPS_CTRL_OFS, 32'h0);
      `CHK("ctrl init", 32'h0, rdat)
      xfer(1'b0, `LPS_ISLOT_BASE + 12'h004, 32'h0);
      `CHK("slot kept", 32'h00005F00, rdat)
      xfer(1'b0, `LPS_GSLOT_BASE + {6'h00, g, 2'b00}, 32'h0);
      `CHK("gslot kept", bit_word(b), rdat)
      subsys <= 1'b0;
      rtclp <= 1'b0;
      test_done();
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done();
   end
endmodule

// [tb/lps_trig_src.sv]
// trigger source model: one pulse on a chosen line per fire request
// assumes fire is raised for one cycle just after a rising edge
`timescale 1ns/1ps
module lps_trig_src
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic fire,
   input wire logic [4:0] sel,
   output logic [31:0] trigger_in
);
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         trigger_in <= 32'h0;
      else if (fire)
         trigger_in <= 32'h1 << sel;
      else
         trigger_in <= 32'h0;
   end
endmodule
